// >>> rtl/keypad_nav_pkg.sv
// keypad navigation and editor: shared constants, types and carriers
// assumes one 50 MHz clock; key levels are high while a key is pressed
package keypad_nav_pkg;

  // clock and timing
  localparam int CLOCK_HZ = 50_000_000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
  localparam int LIMIT_FLASH_MS = 3000;
  localparam int LIMIT_FLASH_COUNT = LIMIT_FLASH_MS * CYCLES_PER_MS;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_COUNT = DEBOUNCE_MS * CYCLES_PER_MS;
  localparam int REPEAT_DELAY_MS = 500;
  localparam int REPEAT_DELAY_COUNT = REPEAT_DELAY_MS * CYCLES_PER_MS;
  localparam int REPEAT_PERIOD_MS = 100;
  localparam int REPEAT_PERIOD_COUNT = REPEAT_PERIOD_MS * CYCLES_PER_MS;
  localparam int ACCEL_MS = 2000;
  localparam int ACCEL_COUNT = ACCEL_MS * CYCLES_PER_MS;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_COUNT = BLINK_HALF_MS * CYCLES_PER_MS;
  localparam int COUNT_W = 28;

  // menu and parameter space
  localparam int MENU_TOP = 22;
  localparam int MENU_COUNT = 23;
  localparam int MENU_W = 5;
  localparam int PARAM_W = 8;
  localparam int KEY_COUNT = 5;
  localparam int MAX_DIGITS = 10;
  localparam int DIGIT_W = 4;

  // displayable value span
  localparam logic signed [31:0] SHOW_MIN = -32'sh000F423F;
  localparam logic signed [31:0] SHOW_MAX = 32'sh0098967F;

  // acceleration multipliers on the least significant digit
  localparam logic signed [39:0] STEP_SLOW = 40'sh0000000001;
  localparam logic signed [39:0] STEP_MID = 40'sh000000000A;
  localparam logic signed [39:0] STEP_FAST = 40'sh0000000064;

  typedef enum logic [1:0] {MODE_STATUS, MODE_VIEW, MODE_EDIT} display_mode_e;

  typedef enum logic [3:0] {
    STATUS_INHIBITED, STATUS_READY, STATUS_STOPPED, STATUS_RUNNING, STATUS_SCANNING,
    STATUS_SUPPLY_LOSS_DECEL, STATUS_RAMPING_DOWN, STATUS_DC_BRAKING, STATUS_POSITIONING,
    STATUS_TRIPPED, STATUS_REGEN_SYNCED
  } status_e;

  typedef struct packed {
    logic up;
    logic down;
    logic left;
    logic right;
    logic mode;
  } keys_s;

  typedef struct packed {
    logic enable;
    logic inverterActive;
    logic zeroSpeed;
    logic scanning;
    logic supplyLoss;
    logic rampingDown;
    logic dcBraking;
    logic positioning;
    logic tripped;
    logic regenSynced;
  } drive_state_s;

  typedef struct packed {
    logic signed [31:0] value;
    logic signed [31:0] maximum;
    logic signed [31:0] minimum;
    logic isString;
    logic [PARAM_W-1:0] topParam;
  } param_info_s;

  typedef struct packed {
    logic [MENU_W-1:0] menu;
    logic [PARAM_W-1:0] param;
  } param_addr_s;

  typedef struct packed {
    display_mode_e mode;
    status_e status;
    param_addr_s addr;
    logic signed [31:0] value;
    logic dashes;
    logic [DIGIT_W-1:0] digit;
    logic blankDigit;
    logic blankAll;
  } display_s;

  typedef struct packed {
    logic strobe;
    param_addr_s addr;
    logic signed [31:0] value;
  } param_write_s;

endpackage

// >>> rtl/keypad_navigation_editor.sv
// keypad navigation and editor: status, parameter view and digit editing
// assumes the parameter store answers paramInfo for display.addr in the same cycle
`timescale 1ns/1ps
`default_nettype none

module keypad_navigation_editor
  import keypad_nav_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_COUNT,
  parameter int REPEAT_DELAY_CYCLES = REPEAT_DELAY_COUNT,
  parameter int REPEAT_PERIOD_CYCLES = REPEAT_PERIOD_COUNT,
  parameter int ACCEL_CYCLES = ACCEL_COUNT,
  parameter int BLINK_HALF_CYCLES = BLINK_HALF_COUNT,
  parameter int LIMIT_FLASH_CYCLES = LIMIT_FLASH_COUNT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire keys_s keys,
  input wire logic advancedAccess,
  input wire drive_state_s driveState,
  input wire param_info_s paramInfo,
  output var display_s display,
  output var param_write_s paramWrite
);

  localparam logic [COUNT_W-1:0] DEB_LAST = COUNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [COUNT_W-1:0] REP_DELAY_LAST = COUNT_W'(REPEAT_DELAY_CYCLES - 1);
  localparam logic [COUNT_W-1:0] REP_PERIOD_LAST = COUNT_W'(REPEAT_PERIOD_CYCLES - 1);
  localparam logic [COUNT_W-1:0] ACCEL_ONE = COUNT_W'(ACCEL_CYCLES);
  localparam logic [COUNT_W-1:0] ACCEL_TWO = COUNT_W'(2 * ACCEL_CYCLES);
  localparam logic [COUNT_W-1:0] BLINK_LAST = COUNT_W'(BLINK_HALF_CYCLES - 1);
  localparam logic [COUNT_W-1:0] LIMIT_LAST = COUNT_W'(LIMIT_FLASH_CYCLES - 1);
  localparam logic [MENU_W-1:0] MENU_LAST = MENU_W'(MENU_TOP);

  typedef struct packed {
    logic [KEY_COUNT-1:0] keySync1;
    logic [KEY_COUNT-1:0] keySync2;
    logic [KEY_COUNT-1:0] keyStable;
    logic [KEY_COUNT-1:0] keyPrev;
    logic [KEY_COUNT-1:0][COUNT_W-1:0] debCount;
    logic [COUNT_W-1:0] holdCount;
    logic [COUNT_W-1:0] repeatTimer;
    logic [COUNT_W-1:0] blinkTimer;
    logic [COUNT_W-1:0] limitTimer;
    logic blinkOff;
    logic [MENU_COUNT-1:0][PARAM_W-1:0] lastParam;
    logic signed [31:0] editValue;
    logic signed [31:0] limitValue;
    logic [DIGIT_W-1:0] selDigit;
    logic limitFlash;
    display_s display;
    param_write_s paramWrite;
  } state_s;

  state_s cur;
  state_s next_cur;

  // decoded key events, shared with the checks
  keys_s held;
  keys_s press;
  logic repeatTick;
  logic udCombo;
  logic lrCombo;
  logic upEvent;
  logic downEvent;
  logic adjusting;
  logic selectable;
  logic [DIGIT_W-1:0] digits;

  // ten to the power n, wide enough for any 32-bit value
  function automatic logic signed [39:0] pow10(input logic [DIGIT_W-1:0] n);
    logic signed [39:0] p;
    p = STEP_SLOW;
    for (int k = 0; k < MAX_DIGITS; k++) begin
      if (DIGIT_W'(k) < n) begin
        p = 40'(p * STEP_MID);
      end
    end
    return p;
  endfunction

  // number of decimal digits needed for a maximum
  function automatic logic [DIGIT_W-1:0] digitsOf(input logic signed [31:0] v);
    logic [DIGIT_W-1:0] n;
    n = DIGIT_W'(1);
    for (int k = 1; k < MAX_DIGITS; k++) begin
      if ($signed({{8{v[31]}}, v}) >= pow10(DIGIT_W'(k))) begin
        n = DIGIT_W'(k + 1);
      end
    end
    return n;
  endfunction

  function automatic logic offScale(input logic signed [31:0] v);
    return (v < SHOW_MIN) || (v > SHOW_MAX);
  endfunction

  // status code by priority: trip first, then enable, then activity
  function automatic status_e statusOf(input drive_state_s d);
    status_e s;
    if (d.tripped) s = STATUS_TRIPPED;
    else if (!d.enable) s = STATUS_INHIBITED;
    else if (d.supplyLoss) s = STATUS_SUPPLY_LOSS_DECEL;
    else if (d.dcBraking) s = STATUS_DC_BRAKING;
    else if (d.positioning) s = STATUS_POSITIONING;
    else if (d.rampingDown) s = STATUS_RAMPING_DOWN;
    else if (d.scanning) s = STATUS_SCANNING;
    else if (d.regenSynced && d.inverterActive) s = STATUS_REGEN_SYNCED;
    else if (!d.inverterActive) s = STATUS_READY;
    else if (d.zeroSpeed) s = STATUS_STOPPED;
    else s = STATUS_RUNNING;
    return s;
  endfunction

  // next state of the whole block
  always_comb begin
    logic [PARAM_W-1:0] p;
    logic [MENU_W-1:0] m;
    logic signed [39:0] delta;
    logic signed [39:0] trial;
    logic signed [39:0] stepMul;
    logic signed [31:0] newValue;
    logic signed [31:0] shown;
    p = cur.display.addr.param;
    m = cur.display.addr.menu;
    delta = '0;
    trial = '0;
    stepMul = STEP_SLOW;
    newValue = cur.editValue;
    shown = paramInfo.value;
    next_cur = cur;
    next_cur.paramWrite.strobe = 1'b0;

    // two-flop synchroniser and per-key debounce
    next_cur.keySync1 = keys;
    next_cur.keySync2 = cur.keySync1;
    for (int i = 0; i < KEY_COUNT; i++) begin
      if (cur.keySync2[i] != cur.keyStable[i]) begin
        if (cur.debCount[i] == DEB_LAST) begin
          next_cur.keyStable[i] = cur.keySync2[i];
          next_cur.debCount[i] = '0;
        end else begin
          next_cur.debCount[i] = cur.debCount[i] + 1'b1;
        end
      end else begin
        next_cur.debCount[i] = '0;
      end
    end
    next_cur.keyPrev = cur.keyStable;
    held = cur.keyStable;
    press = cur.keyStable & ~cur.keyPrev;

    // hold timing restarts whenever the set of held keys changes
    repeatTick = 1'b0;
    if (cur.keyStable != cur.keyPrev) begin
      next_cur.holdCount = '0;
      next_cur.repeatTimer = REP_DELAY_LAST;
    end else begin
      if (cur.holdCount != '1) next_cur.holdCount = cur.holdCount + 1'b1;
      if (cur.repeatTimer == '0) begin
        repeatTick = |cur.keyStable;
        next_cur.repeatTimer = REP_PERIOD_LAST;
      end else begin
        next_cur.repeatTimer = cur.repeatTimer - 1'b1;
      end
    end
    if (cur.holdCount >= ACCEL_TWO && cur.keyStable == cur.keyPrev) stepMul = STEP_FAST;
    else if (cur.holdCount >= ACCEL_ONE && cur.keyStable == cur.keyPrev) stepMul = STEP_MID;

    // blink phase divider
    if (cur.blinkTimer == BLINK_LAST) begin
      next_cur.blinkTimer = '0;
      next_cur.blinkOff = ~cur.blinkOff;
    end else begin
      next_cur.blinkTimer = cur.blinkTimer + 1'b1;
    end

    udCombo = held.up && held.down && (press.up || press.down);
    lrCombo = held.left && held.right && (press.left || press.right);
    upEvent = held.up && !held.down && (press.up || repeatTick);
    downEvent = held.down && !held.up && (press.down || repeatTick);
    adjusting = held.up ^ held.down;
    selectable = !paramInfo.isString && (paramInfo.maximum > 32'sh00000009);
    digits = selectable ? digitsOf(paramInfo.maximum) : DIGIT_W'(1);

    next_cur.display.status = statusOf(driveState);

    case (cur.display.mode)
      MODE_STATUS: begin
        if (press.mode) next_cur.display.mode = MODE_VIEW;
      end
      MODE_VIEW: begin
        if (press.mode) begin
          // off-span values skip edit entirely
          next_cur.display.mode = offScale(paramInfo.value) ? MODE_STATUS : MODE_EDIT;
          next_cur.editValue = paramInfo.value;
          next_cur.selDigit = '0;
          next_cur.limitFlash = 1'b0;
        end else begin
          // parameter within the menu
          if (udCombo) p = '0;
          else if (upEvent && press.up) p = (p >= paramInfo.topParam) ? '0 : p + 1'b1;
          else if (upEvent && p < paramInfo.topParam) p = p + 1'b1;
          else if (downEvent && press.down) p = (p == '0) ? paramInfo.topParam : p - 1'b1;
          else if (downEvent && p != '0) p = p - 1'b1;
          // menu selection
          if (!advancedAccess) m = '0;
          else if (lrCombo) m = '0;
          else if (held.right && !held.left && press.right) begin
            m = (m == MENU_LAST) ? '0 : m + 1'b1;
          end else if (held.right && !held.left && repeatTick && m < MENU_LAST) begin
            m = m + 1'b1;
          end else if (held.left && !held.right && press.left) begin
            m = (m == '0) ? MENU_LAST : m - 1'b1;
          end else if (held.left && !held.right && repeatTick && m != '0) begin
            m = m - 1'b1;
          end
          if (m != cur.display.addr.menu) p = cur.lastParam[m];
          next_cur.lastParam[m] = p;
          next_cur.display.addr.menu = m;
          next_cur.display.addr.param = p;
        end
      end
      MODE_EDIT: begin
        if (press.mode) begin
          next_cur.display.mode = MODE_STATUS;
          next_cur.limitFlash = 1'b0;
        end else if (cur.limitFlash) begin
          if (!held.up && !held.down) begin
            next_cur.limitFlash = 1'b0;
          end else if (cur.limitTimer == LIMIT_LAST) begin
            next_cur.limitFlash = 1'b0;
            newValue = cur.limitValue;
          end else begin
            next_cur.limitTimer = cur.limitTimer + 1'b1;
          end
        end else if (offScale(paramInfo.value)) begin
          newValue = cur.editValue;
        end else if (udCombo) begin
          newValue = '0;
        end else if (selectable && press.left && !held.right) begin
          next_cur.selDigit = (cur.selDigit == digits - 1'b1) ? '0 : cur.selDigit + 1'b1;
        end else if (selectable && press.right && !held.left) begin
          next_cur.selDigit = (cur.selDigit == '0) ? digits - 1'b1 : cur.selDigit - 1'b1;
        end else if (upEvent || downEvent) begin
          delta = (cur.selDigit == '0) ? 40'(stepMul) : pow10(cur.selDigit);
          if (upEvent) trial = $signed({{8{cur.editValue[31]}}, cur.editValue}) + delta;
          else trial = $signed({{8{cur.editValue[31]}}, cur.editValue}) - delta;
          if (trial > $signed({{8{paramInfo.maximum[31]}}, paramInfo.maximum})) begin
            if (cur.selDigit == '0) newValue = paramInfo.maximum;
            else begin
              next_cur.limitFlash = 1'b1;
              next_cur.limitValue = paramInfo.maximum;
              next_cur.limitTimer = '0;
            end
          end else if (trial < $signed({{8{paramInfo.minimum[31]}}, paramInfo.minimum})) begin
            if (cur.selDigit == '0) newValue = paramInfo.minimum;
            else begin
              next_cur.limitFlash = 1'b1;
              next_cur.limitValue = paramInfo.minimum;
              next_cur.limitTimer = '0;
            end
          end else begin
            newValue = trial[31:0];
          end
        end
        if (newValue != cur.editValue || (udCombo && !cur.limitFlash
            && !offScale(paramInfo.value)) || (cur.limitFlash && !press.mode
            && !next_cur.limitFlash && (held.up || held.down))) begin
          next_cur.editValue = newValue;
          next_cur.paramWrite.strobe = 1'b1;
          next_cur.paramWrite.addr = cur.display.addr;
          next_cur.paramWrite.value = newValue;
        end
        if (next_cur.selDigit >= digits) next_cur.selDigit = '0;
      end
      default: next_cur.display.mode = MODE_STATUS;
    endcase

    // value row and flashing
    if (cur.display.mode == MODE_EDIT) begin
      shown = cur.limitFlash ? cur.limitValue : cur.editValue;
    end
    next_cur.display.value = shown;
    next_cur.display.dashes = offScale(shown);
    next_cur.display.digit = cur.selDigit;
    next_cur.display.blankDigit = (cur.display.mode == MODE_EDIT) && selectable && !adjusting
                                  && !cur.limitFlash && cur.blinkOff;
    next_cur.display.blankAll = (cur.display.mode == MODE_EDIT) && cur.blinkOff
                                && (cur.limitFlash || (paramInfo.isString && !adjusting));
  end

  // single state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur <= state_s'('0);
    end else begin
      cur <= next_cur;
    end
  end

  assign display = cur.display;
  assign paramWrite = cur.paramWrite;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_menu_ceiling: assert property (display.addr.menu <= MENU_LAST)
    else $error("menu number above the top menu");
  chk_locked_menu: assert property (!advancedAccess && display.mode == MODE_VIEW
    |=> display.addr.menu == '0)
    else $error("menu left zero without advanced access");
  chk_menu_wrap: assert property (display.mode == MODE_VIEW && advancedAccess
    && !press.mode && press.right && !held.left && display.addr.menu == MENU_LAST
    |=> display.addr.menu == '0)
    else $error("single right at top menu did not wrap");
  chk_lr_zero: assert property (display.mode == MODE_VIEW && lrCombo && !press.mode
    |=> display.addr.menu == '0)
    else $error("left and right together did not select menu zero");
  chk_ud_param_zero: assert property (display.mode == MODE_VIEW && udCombo
    && !press.mode && !held.left && !held.right && display.addr.menu == '0
    |=> display.addr.param == '0)
    else $error("up and down together did not select parameter zero");
  chk_ud_zero_write: assert property (display.mode == MODE_EDIT && udCombo
    && !press.mode && !cur.limitFlash && !offScale(paramInfo.value)
    |=> paramWrite.strobe && paramWrite.value == '0)
    else $error("edit zero shortcut did not write zero");
  chk_dash_span: assert property (display.dashes == offScale(display.value))
    else $error("dash pattern disagrees with value span");
  chk_steady_adjust: assert property (display.mode == MODE_EDIT && adjusting
    && !press.mode && !cur.limitFlash |=> !display.blankDigit)
    else $error("digit flashed during adjustment");
  chk_limit_commit: assert property (display.mode == MODE_EDIT && cur.limitFlash
    && !press.mode && cur.limitTimer == LIMIT_LAST && (held.up || held.down)
    |=> paramWrite.strobe && paramWrite.value == $past(cur.limitValue) && !cur.limitFlash)
    else $error("limit not written when flash time ended");
  chk_status_code: assert property (driveState.tripped
    |=> display.status == STATUS_TRIPPED)
    else $error("trip not shown as status");
  chk_status_inh: assert property (!driveState.tripped && !driveState.enable
    |=> display.status == STATUS_INHIBITED)
    else $error("disabled drive not shown as inhibited");

endmodule

`default_nettype wire

// >>> dv/param_store_model.sv
// parameter store model: answers the editor's reads and takes its writes
// assumes one address is read per cycle and writes come as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none

module param_store_model
  import keypad_nav_pkg::*;
(
  input wire logic clock,
  input wire param_addr_s addr,
  input wire logic stringParam,
  input wire param_write_s write,
  output var param_info_s info
);
  logic signed [31:0] mem [0:8191];

  // param 3 starts near its maximum, param 4 lies off the displayable span
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = (i % 256 == 3) ? 32'sh000003E6 : (i % 256 == 4) ? 32'sh7FFFFFFF : 32'sh00000064;
    end
  end

  // writes land on the strobe edge
  always @(posedge clock) begin
    if (write.strobe) begin
      mem[write.addr] <= write.value;
    end
  end

  // same-cycle answer for the shown address
  always_comb begin
    info.value = mem[addr];
    info.maximum = 32'sh000003E8;
    info.minimum = -32'sh000003E8;
    info.isString = stringParam;
    info.topParam = (addr.menu == '0) ? 8'h04 : 8'h06;
  end
endmodule

`default_nettype wire

// >>> dv/tb_keypad_navigation_editor.sv
// testbench: status table, then navigation and editing by key presses
// assumes the store model answers reads in the same cycle
`timescale 1ns/1ps
`default_nettype none

module tb_keypad_navigation_editor import keypad_nav_pkg::*;;
  typedef struct packed {
    drive_state_s ds;
    status_e st;
  } status_row_s;

  localparam keys_s UP = 5'b10000;
  localparam keys_s DOWN = 5'b01000;
  localparam keys_s LEFT = 5'b00100;
  localparam keys_s RIGHT = 5'b00010;
  localparam keys_s MODE = 5'b00001;

  logic clock = 1'b0;
  logic reset_n = 1'b0;
  keys_s keys = '0;
  logic advancedAccess = 1'b0;
  drive_state_s driveState = '0;
  param_info_s paramInfo;
  display_s display;
  param_write_s paramWrite;
  int failures = 0;
  int n_compared = 0;
  logic blankSeen = 1'b0;
  logic stringParam = 1'b0;
  status_row_s rows [11] = '{
    '{10'b0000000000, STATUS_INHIBITED}, '{10'b1000000000, STATUS_READY},
    '{10'b1110000000, STATUS_STOPPED}, '{10'b1100000000, STATUS_RUNNING},
    '{10'b1101000000, STATUS_SCANNING}, '{10'b1100100000, STATUS_SUPPLY_LOSS_DECEL},
    '{10'b1100010000, STATUS_RAMPING_DOWN}, '{10'b1100001000, STATUS_DC_BRAKING},
    '{10'b1100000100, STATUS_POSITIONING}, '{10'b0000000010, STATUS_TRIPPED},
    '{10'b1100000001, STATUS_REGEN_SYNCED}};

  // 50 MHz clock
  always #10 clock = ~clock;

  keypad_navigation_editor #(.DEBOUNCE_CYCLES(4), .REPEAT_DELAY_CYCLES(20),
    .REPEAT_PERIOD_CYCLES(8), .ACCEL_CYCLES(40), .BLINK_HALF_CYCLES(4),
    .LIMIT_FLASH_CYCLES(50)) u_dut (
    .clock(clock), .reset_n(reset_n), .keys(keys), .advancedAccess(advancedAccess),
    .driveState(driveState), .paramInfo(paramInfo), .display(display),
    .paramWrite(paramWrite));

  param_store_model u_store (.clock(clock), .addr(display.addr), .write(paramWrite),
    .stringParam(stringParam), .info(paramInfo));

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // hold a key set, note any blanking once the press has registered
  task automatic press(input keys_s k, input int hold);
    keys = k;
    for (int i = 0; i < hold; i++) begin
      step(1);
      if (i > 10 && (display.blankAll | display.blankDigit) !== 1'b0) blankSeen = 1'b1;
    end
    keys = '0;
    step(12);
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic results();
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end

  // main sequence
  initial begin
    step(10);
    reset_n = 1'b1;
    step(1);
    check("mode", MODE_STATUS, display.mode);
    check("strobe", 0, paramWrite.strobe);
    foreach (rows[i]) begin
      driveState = rows[i].ds;
      step(3);
      check("status", rows[i].st, display.status);
    end
    driveState = rows[3].ds;
    press(MODE, 12);
    check("mode", MODE_VIEW, display.mode);
    press(RIGHT, 12);
    check("menu", 0, display.addr.menu);
    press(DOWN, 12);
    check("param", 4, display.addr.param);
    press(UP, 12);
    check("param", 0, display.addr.param);
    press(UP, 100);
    check("param", 4, display.addr.param);
    press(UP | DOWN, 12);
    check("param", 0, display.addr.param);
    press(DOWN, 100);
    check("param", 0, display.addr.param);
    press(UP, 12);
    press(UP, 12);
    advancedAccess = 1'b1;
    press(RIGHT, 12);
    check("menu", 1, display.addr.menu);
    check("param", 0, display.addr.param);
    press(UP, 12);
    press(LEFT, 12);
    check("param", 2, display.addr.param);
    press(LEFT, 12);
    check("menu", 22, display.addr.menu);
    press(RIGHT, 12);
    check("menu", 0, display.addr.menu);
    press(RIGHT, 230);
    check("menu", 22, display.addr.menu);
    press(LEFT | RIGHT, 12);
    check("menu", 0, display.addr.menu);
    check("value", 100, display.value);
    press(MODE, 12);
    check("mode", MODE_EDIT, display.mode);
    press(UP, 12);
    check("value", 101, display.value);
    check("written", 101, paramWrite.value);
    press(DOWN, 12);
    check("value", 100, display.value);
    press(UP | DOWN, 12);
    check("value", 0, display.value);
    press(MODE, 12);
    check("mode", MODE_STATUS, display.mode);
    check("param", 2, display.addr.param);
    press(MODE, 12);
    press(UP, 12);
    press(MODE, 12);
    blankSeen = 1'b0;
    press(UP, 250);
    check("blank", 0, blankSeen);
    check("value", 1000, display.value);
    press(RIGHT, 12);
    check("digit", 3, display.digit);
    press(LEFT, 12);
    check("digit", 0, display.digit);
    press(DOWN, 12);
    check("value", 999, display.value);
    press(RIGHT, 12);
    press(UP, 12);
    check("value", 999, display.value);
    check("written", 999, paramWrite.value);
    blankSeen = 1'b0;
    press(UP, 120);
    check("blank", 1, blankSeen);
    check("written", 1000, paramWrite.value);
    check("write addr", 3, paramWrite.addr);
    check("value", 1000, display.value);
    press(MODE, 12);
    press(MODE, 12);
    press(UP, 12);
    check("dashes", 1, display.dashes);
    press(MODE, 12);
    check("mode", MODE_STATUS, display.mode);
    press(MODE, 12);
    press(DOWN, 12);
    stringParam = 1'b1;
    press(MODE, 12);
    check("mode", MODE_EDIT, display.mode);
    blankSeen = 1'b0;
    press(RIGHT, 30);
    check("blank", 1, blankSeen);
    check("digit", 0, display.digit);
    press(MODE, 12);
    reset_n = 1'b0;
    step(2);
    check("param", 0, display.addr.param);
    reset_n = 1'b1;
    step(1);
    check("status", STATUS_RUNNING, display.status);
    check("mode", MODE_STATUS, display.mode);
    results();
  end
endmodule

`default_nettype wire
